// ==== rtl/tbc_cond_eval.sv ====
`timescale 1ns/1ps
`default_nettype none
// condition predicate and bounds compare, purely combinational
module tbc_cond_eval
(
    input  wire logic [3:0]  cond,
    input  wire logic [3:0]  flags,
    input  wire logic [31:0] operand,
    input  wire logic [31:0] lower,
    input  wire logic [31:0] upper,
    input  wire logic        is_signed,
    output logic             pred_true,
    output logic             out_of_range,
    output logic             on_limit
);
    // flags order n z v c
    wire n = flags[3];
    wire z = flags[2];
    wire v = flags[1];
    wire c = flags[0];
    logic [15:0] table_w;

    assign table_w = {(n ^ v) | z, ~(n ^ v) & ~z, n ^ v, ~(n ^ v), n, ~n,
                      v, ~v, z, ~z, c, ~c, c | z, ~c & ~z, 1'b0, 1'b1};
    assign pred_true = table_w[cond];

    // sign bit flipped turns a signed compare into an unsigned one
    wire [31:0] flip = {is_signed, 31'h0};
    wire [31:0] op_x = operand ^ flip;
    wire [31:0] lo_x = lower ^ flip;
    wire [31:0] hi_x = upper ^ flip;
    assign out_of_range = (op_x < lo_x) | (op_x > hi_x);
    assign on_limit     = (operand == lower) | (operand == upper);
endmodule : tbc_cond_eval
`default_nettype wire

// ==== rtl/tbc_pkg.sv ====
// Function
// - bounds ops check operand against both limits, signed or unsigned
// - bounds compare only sets flags; bounds check also traps on violation
// - conditional trap takes any flag predicate, traps only when it is true
// - conditional trap hands zero, one or two extension words to the handler
// - breakpoint runs acknowledge cycle with 3-bit id on address bits 4:2
// - after a proper acknowledge, core runs the received word instead
// - bus error pushes internal execution state onto the supervisor stack
// - after saving state, program counter loads from vector entry two
// - return restores state, reruns the faulted cycle if needed, continues
package tbc_pkg;

    localparam int          STATE_WORDS   = 4;
    localparam logic [7:0]  VEC_BUS_ERR   = 8'h02;
    localparam logic [7:0]  VEC_BOUNDS    = 8'h06;
    localparam logic [7:0]  VEC_CTRAP     = 8'h07;
    localparam logic [7:0]  VEC_ILLEGAL   = 8'h04;
    localparam logic [31:0] STACK_RESET   = 32'h0000_1000;
    localparam logic [31:0] VBR_RESET     = 32'h0000_0000;
    localparam logic [31:0] ACK_SPACE     = 32'hffff_0000;

    // operations handed in by the decoder
    typedef enum logic [2:0]
    {
        TBC_OP_NONE  = 3'b000,
        TBC_OP_BCMP  = 3'b001,
        TBC_OP_BCHK  = 3'b010,
        TBC_OP_CTRAP = 3'b011,
        TBC_OP_BREAKPOINT_INSTR  = 3'b100,
        TBC_OP_RET   = 3'b101
    } tbc_op_e;

    typedef enum logic [3:0]
    {
        TBC_IDLE   = 4'b0000,
        TBC_BKACK  = 4'b0001,
        TBC_PUSH   = 4'b0010,
        TBC_VREAD  = 4'b0011,
        TBC_POP    = 4'b0100,
        TBC_RERUN  = 4'b0101,
        TBC_DONE   = 4'b0110
    } tbc_state_e;

endpackage : tbc_pkg

// ==== rtl/tbc_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
// exception side of the core: bounds, conditional traps, breakpoint
// acknowledge and bus-error continuation
module tbc_unit
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        op_valid,
    input  wire logic [2:0]  op_code,
    input  wire logic [3:0]  op_cond,
    input  wire logic        op_signed,
    input  wire logic [1:0]  op_ext_count,
    input  wire logic [15:0] op_ext0,
    input  wire logic [15:0] op_ext1,
    input  wire logic [2:0]  op_breakpoint_instr_id,
    input  wire logic [31:0] op_operand,
    input  wire logic [31:0] op_lower,
    input  wire logic [31:0] op_upper,
    input  wire logic [3:0]  flags_in,
    input  wire logic [31:0] pc_in,
    input  wire logic [31:0] fault_addr,
    input  wire logic        fault_rerun,
    input  wire logic        bus_err,
    input  wire logic        bus_ack,
    input  wire logic [31:0] bus_rdata,
    output logic             op_ready,
    output logic             bus_req,
    output logic             bus_we,
    output logic             bus_breakpoint_instr_ack,
    output logic [31:0]      bus_addr,
    output logic [31:0]      bus_wdata,
    output logic             flags_we,
    output logic [3:0]       flags_out,
    output logic             trap_take,
    output logic [7:0]       trap_vector,
    output logic [31:0]      trap_info,
    output logic             subst_valid,
    output logic [15:0]      subst_word,
    output logic             pc_load,
    output logic [31:0]      pc_out,
    output logic             rerun_req,
    output logic [31:0]      rerun_addr,
    output logic             resume
);
    tbc_pkg::tbc_state_e state_r;
    tbc_pkg::tbc_state_e state_nxt;
    logic [31:0] sp_r;
    logic [1:0]  idx_r;
    logic [31:0] save_r [tbc_pkg::STATE_WORDS];
    logic        pred_w;
    logic        oor_w;
    logic        lim_w;

    tbc_cond_eval u_eval
    (
        .cond         (op_cond),
        .flags        (flags_in),
        .operand      (op_operand),
        .lower        (op_lower),
        .upper        (op_upper),
        .is_signed    (op_signed),
        .pred_true    (pred_w),
        .out_of_range (oor_w),
        .on_limit     (lim_w)
    );

    // decode of an accepted operation
    wire         idle_w   = (state_r == tbc_pkg::TBC_IDLE);
    wire         take_w   = clk_en & idle_w & op_valid & op_ready;
    wire         is_bnd   = (op_code == tbc_pkg::TBC_OP_BCMP)
                          | (op_code == tbc_pkg::TBC_OP_BCHK);
    wire         bnd_trap = (op_code == tbc_pkg::TBC_OP_BCHK) & oor_w;
    wire         ct_trap  = (op_code == tbc_pkg::TBC_OP_CTRAP) & pred_w;
    wire [3:0]   bnd_fl   = {flags_in[3], lim_w, flags_in[1], oor_w};
    wire [15:0]  ext1_w   = (op_ext_count == 2'd2) ? op_ext1 : 16'h0000;
    wire [15:0]  ext0_w   = (op_ext_count != 2'd0) ? op_ext0 : 16'h0000;
    wire [31:0]  info_w   = {ext1_w, ext0_w};
    wire         err_w    = bus_req & bus_err;
    wire         ack_w    = bus_req & bus_ack & ~bus_err;
    wire         last_w   = (idx_r == 2'(tbc_pkg::STATE_WORDS - 1));
    wire [31:0]  vec_addr = tbc_pkg::VBR_RESET
                          + {22'h0, tbc_pkg::VEC_BUS_ERR, 2'b00};
    wire [31:0]  push_sp  = sp_r - 32'h0000_0004;

    // words go out highest first, so the climbing pops land each word
    // back in its own slot; the first word bypasses the snapshot, which
    // is only being written at that same edge
    wire [1:0]   wr_idx   = ack_w ? ~2'(idx_r + 2'b01) : ~idx_r;
    wire [31:0]  wr_data  = (state_r == tbc_pkg::TBC_PUSH)
                          ? save_r[wr_idx] : {28'h0, flags_in};

    // state sequencing
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            tbc_pkg::TBC_IDLE:
                if (take_w & (op_code == tbc_pkg::TBC_OP_BREAKPOINT_INSTR))
                    state_nxt = tbc_pkg::TBC_BKACK;
                else if (take_w & (op_code == tbc_pkg::TBC_OP_RET))
                    state_nxt = tbc_pkg::TBC_POP;
            tbc_pkg::TBC_BKACK:
                if (err_w)
                    state_nxt = tbc_pkg::TBC_IDLE; // no substitute: illegal trap
                else if (ack_w)
                    state_nxt = tbc_pkg::TBC_IDLE;
            tbc_pkg::TBC_PUSH:
                if (ack_w & last_w)
                    state_nxt = tbc_pkg::TBC_VREAD;
            tbc_pkg::TBC_VREAD:
                if (ack_w)
                    state_nxt = tbc_pkg::TBC_IDLE;
            tbc_pkg::TBC_POP:
                if (ack_w & last_w)
                    state_nxt = tbc_pkg::TBC_RERUN;
            tbc_pkg::TBC_RERUN:
                state_nxt = tbc_pkg::TBC_DONE;
            tbc_pkg::TBC_DONE:
                state_nxt = tbc_pkg::TBC_IDLE;
            default:
                state_nxt = tbc_pkg::TBC_IDLE;
        endcase
        // a bus error while idle, outside our own cycles, starts state saving
        if (idle_w & clk_en & bus_err & ~bus_req)
            state_nxt = tbc_pkg::TBC_PUSH;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            state_r <= tbc_pkg::TBC_IDLE;
        else if (clk_en)
            state_r <= state_nxt;
    end

    // stack pointer and save words; the save array holds a snapshot
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sp_r  <= tbc_pkg::STACK_RESET;
            idx_r <= 2'b00;
        end
        else if (clk_en)
        begin
            if (state_r != state_nxt)
                idx_r <= 2'b00;
            else if (ack_w)
                idx_r <= idx_r + 2'b01;
            if (ack_w & (state_r == tbc_pkg::TBC_PUSH))
                sp_r <= push_sp;
            else if (ack_w & (state_r == tbc_pkg::TBC_POP))
                sp_r <= sp_r + 32'h0000_0004;
        end
    end

    // snapshot of the faulted context taken at the error
    always_ff @(posedge sys_clk)
    begin
        if (clk_en & idle_w & bus_err & ~bus_req)
        begin
            save_r[0] <= pc_in;
            save_r[1] <= fault_addr;
            save_r[2] <= {31'h0, fault_rerun};
            save_r[3] <= {28'h0, flags_in};
        end
        else if (clk_en & ack_w & (state_r == tbc_pkg::TBC_POP))
            save_r[idx_r] <= bus_rdata;
    end

    // bus request outputs, registered
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bus_req      <= 1'b0;
            bus_we       <= 1'b0;
            bus_breakpoint_instr_ack <= 1'b0;
            bus_addr     <= 32'h0000_0000;
            bus_wdata    <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            bus_req      <= (state_nxt == tbc_pkg::TBC_BKACK)
                          | (state_nxt == tbc_pkg::TBC_PUSH)
                          | (state_nxt == tbc_pkg::TBC_VREAD)
                          | (state_nxt == tbc_pkg::TBC_POP);
            bus_we       <= (state_nxt == tbc_pkg::TBC_PUSH);
            bus_breakpoint_instr_ack <= (state_nxt == tbc_pkg::TBC_BKACK);
            bus_wdata    <= wr_data;
            case (state_nxt)
                tbc_pkg::TBC_BKACK:
                    bus_addr <= tbc_pkg::ACK_SPACE
                              | {27'h0, op_breakpoint_instr_id, 2'b00};
                tbc_pkg::TBC_PUSH:
                    bus_addr <= (state_r == tbc_pkg::TBC_PUSH & ack_w)
                              ? push_sp - 32'h0000_0004 : push_sp;
                tbc_pkg::TBC_VREAD:
                    bus_addr <= vec_addr;
                tbc_pkg::TBC_POP:
                    bus_addr <= (ack_w) ? sp_r + 32'h0000_0004 : sp_r;
                default:
                    bus_addr <= 32'h0000_0000;
            endcase
        end
    end

    // results to the core, one-cycle pulses except op_ready
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            op_ready    <= 1'b0;
            flags_we    <= 1'b0;
            flags_out   <= 4'h0;
            trap_take   <= 1'b0;
            trap_vector <= 8'h00;
            trap_info   <= 32'h0000_0000;
            subst_valid <= 1'b0;
            subst_word  <= 16'h0000;
            pc_load     <= 1'b0;
            pc_out      <= 32'h0000_0000;
            rerun_req   <= 1'b0;
            rerun_addr  <= 32'h0000_0000;
            resume      <= 1'b0;
        end
        else if (clk_en)
        begin
            op_ready    <= (state_nxt == tbc_pkg::TBC_IDLE) & ~take_w;
            flags_we    <= take_w & is_bnd;
            flags_out   <= bnd_fl;
            trap_take   <= (take_w & (bnd_trap | ct_trap))
                         | ((state_r == tbc_pkg::TBC_BKACK) & err_w);
            trap_vector <= (state_r == tbc_pkg::TBC_BKACK)
                         ? tbc_pkg::VEC_ILLEGAL
                         : (ct_trap ? tbc_pkg::VEC_CTRAP
                                    : tbc_pkg::VEC_BOUNDS);
            trap_info   <= info_w;
            subst_valid <= (state_r == tbc_pkg::TBC_BKACK) & ack_w;
            subst_word  <= bus_rdata[15:0];
            pc_load     <= (state_r == tbc_pkg::TBC_VREAD) & ack_w;
            pc_out      <= (state_r == tbc_pkg::TBC_VREAD)
                         ? bus_rdata : save_r[0];
            rerun_req   <= (state_r == tbc_pkg::TBC_RERUN)
                         & save_r[2][0];
            rerun_addr  <= save_r[1];
            resume      <= (state_r == tbc_pkg::TBC_DONE);
        end
    end
endmodule : tbc_unit
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        op_valid = 1'b0;
    logic        op_signed = 1'b0;
    logic        fault_rerun = 1'b0;
    logic        tb_err = 1'b0;
    logic        slow = 1'b0;
    logic        fail_breakpoint_instr = 1'b0;
    logic        clk_en = 1'b1;
    logic [2:0]  op_code = 3'h0;
    logic [2:0]  op_breakpoint_instr_id = 3'h0;
    logic [3:0]  op_cond = 4'h0;
    logic [3:0]  flags_in = 4'h0;
    logic [1:0]  op_ext_count = 2'h0;
    logic [15:0] op_ext0 = 16'h0;
    logic [15:0] op_ext1 = 16'h0;
    logic [31:0] op_operand = 32'h0;
    logic [31:0] op_lower = 32'h0;
    logic [31:0] op_upper = 32'h0;
    logic [31:0] pc_in = 32'h0;
    logic [31:0] fault_addr = 32'h0;
    logic        op_ready, bus_req, bus_we, bus_breakpoint_instr_ack, flags_we, trap_take;
    logic        subst_valid, pc_load, rerun_req, resume, bus_ack, m_err;
    logic [31:0] bus_addr, bus_wdata, trap_info, pc_out, rerun_addr, bus_rdata;
    logic [3:0]  flags_out;
    logic [7:0]  trap_vector;
    logic [15:0] subst_word;
    logic [31:0] seed = 32'h8e2cb679;
    int          err_count = 0;
    int          n_compared = 0;
    wire logic [5:0] evt = {op_ready, subst_valid, trap_take, pc_load,
                            rerun_req, resume};
    tbc_unit DUT (.*, .bus_err(tb_err | m_err));
    tbc_far_model MEM (.*, .bus_err(m_err));
    initial forever #2 sys_clk = ~sys_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // reference bounds result {on a limit, out of range}
    function automatic logic [1:0] bounds();
        longint v, lo, hi;
        v = op_signed ? longint'($signed(op_operand)) : longint'(op_operand);
        lo = op_signed ? longint'($signed(op_lower)) : longint'(op_lower);
        hi = op_signed ? longint'($signed(op_upper)) : longint'(op_upper);
        return {v == lo || v == hi, v < lo || v > hi};
    endfunction : bounds
    // reference predicate over {n, z, v, c}
    function automatic logic pred(input logic [3:0] c, input logic [3:0] f);
        logic [15:0] t;
        t = {f[2] | (f[3] ^ f[1]), !f[2] & !(f[3] ^ f[1]), f[3] ^ f[1],
             !(f[3] ^ f[1]), f[3], !f[3], f[1], !f[1], f[2], !f[2], f[0],
             !f[0], f[0] | f[2], !f[0] & !f[2], 1'b0, 1'b1};
        return t[c];
    endfunction : pred
    task automatic chk(input string what, input logic [32:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    // bounded wait at falling edges for one event bit
    task automatic wait_hi(input int w);
        for (int k = 0; k < 300; k++)
        begin
            if (evt[w] === 1'b1)
                return;
            @(negedge sys_clk);
        end
        $display("wait ran out on event %0d", w);
        err_count++;
        give_verdict();
    endtask : wait_hi
    // offer one op while ready; returns in the answer cycle
    task automatic issue(input logic [2:0] code);
        wait_hi(5);
        op_code = code;
        op_valid = 1'b1;
        @(negedge sys_clk);
        op_valid = 1'b0;
    endtask : issue
    initial
    begin
        logic [31:0] r;
        logic [1:0]  zc;
        logic        e;
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        for (int i = 0; i < 48; i++)
        begin
            r = rnd();
            op_cond = i[3:0];
            flags_in = r[3:0];
            op_signed = r[4];
            op_ext_count = 2'(i % 3);
            op_ext0 = r[31:16];
            op_ext1 = ~r[15:0];
            op_lower = rnd() & 32'h8000_00ff;
            op_upper = op_lower + r[12:5];
            op_operand = r[13] ? op_upper : op_lower + {{24{r[27]}}, r[27:20]};
            zc = bounds();
            issue(3'(1 + i % 3));
            e = op_code == 3'h2 ? zc[0]
                : op_code == 3'h3 && pred(op_cond, r[3:0]);
            chk("trap", trap_take, e);
            if (op_code != 3'h3)
                chk("flags", {flags_we, flags_out[2], flags_out[0]},
                    {1'b1, zc});
            if (e)
                chk("vector", trap_vector,
                    op_code == 3'h2 ? tbc_pkg::VEC_BOUNDS : tbc_pkg::VEC_CTRAP);
            if (e && op_code == 3'h3)
                chk("info", trap_info, {op_ext_count > 1 ? op_ext1 : 16'h0,
                    op_ext_count > 0 ? op_ext0 : 16'h0});
        end
        // an op offered while the enable is low must not be taken
        wait_hi(5);
        clk_en = 1'b0;
        op_code = 3'h2;
        op_valid = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("frozen", {flags_we, op_ready}, 2'b01);
        op_valid = 1'b0;
        clk_en = 1'b1;
        $display("bounds and trap test done");
        for (int i = 0; i < 9; i++)
        begin
            op_breakpoint_instr_id = i[2:0];
            fail_breakpoint_instr = i == 8;
            slow = i[0];
            issue(3'h4);
            wait_hi(i < 8 ? 4 : 3);
            if (i < 8)
                chk("subst", subst_word, 16'ha5a0 ^ i[2:0]);
            else
                chk("breakpoint_instr vector", trap_vector, tbc_pkg::VEC_ILLEGAL);
        end
        $display("breakpoint test done");
        for (int i = 0; i < 2; i++)
        begin
            r = rnd();
            pc_in = r;
            fault_addr = ~r;
            fault_rerun = !i[0];
            slow = i[0];
            wait_hi(5);
            tb_err = 1'b1;
            @(negedge sys_clk);
            tb_err = 1'b0;
            wait_hi(2);
            chk("handler", pc_out, 32'h2000);
            issue(3'h5);
            wait_hi(fault_rerun ? 1 : 0);
            chk("rerun", rerun_req ? {1'b1, rerun_addr} : 33'h0,
                fault_rerun ? {1'b1, fault_addr} : 33'h0);
            if (fault_rerun)
                @(negedge sys_clk);
            chk("resume", resume, 1'b1);
        end
        $display("bus error continuation test done");
        give_verdict();
    end
endmodule : tb
`default_nettype wire

// ==== verification/tbc_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// memory and debugger behind the unit's bus
module tbc_far_model
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        bus_req,
    input  wire logic        bus_we,
    input  wire logic        bus_breakpoint_instr_ack,
    input  wire logic [31:0] bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        slow,
    input  wire logic        fail_breakpoint_instr,
    output var logic         bus_ack,
    output var logic         bus_err,
    output var logic [31:0]  bus_rdata
);
    logic [31:0] mem [logic [31:0]];
    int          wt = 0;
    int          hits [8];
    initial
    begin
        bus_ack = 1'b0;
        bus_err = 1'b0;
        bus_rdata = 32'h0;
    end
    // slow mode waits three cycles; idle data lines churn
    always @(posedge sys_clk)
    begin
        bus_ack <= 1'b0;
        bus_err <= 1'b0;
        bus_rdata <= ~bus_rdata;
        if (rst)
            wt <= 0;
        else if (bus_req && !bus_ack && !bus_err && wt < (slow ? 3 : 0))
            wt <= wt + 1;
        else if (bus_req && !bus_ack && !bus_err)
        begin
            wt <= 0;
            bus_err <= bus_breakpoint_instr_ack && fail_breakpoint_instr;
            bus_ack <= !(bus_breakpoint_instr_ack && fail_breakpoint_instr);
            if (bus_breakpoint_instr_ack)
                hits[bus_addr[4:2]] <= hits[bus_addr[4:2]] + 1;
            if (bus_we)
                mem[bus_addr] = bus_wdata;
            bus_rdata <= bus_breakpoint_instr_ack ? {16'h0, 16'ha5a0 ^ bus_addr[4:2]}
                : bus_addr == 32'h8 ? 32'h2000
                : mem.exists(bus_addr) ? mem[bus_addr] : ~bus_addr;
        end
    end
endmodule : tbc_far_model
`default_nettype wire

// ==== verification/tbc_unit_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the exception unit
module tbc_unit_props
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire logic        op_valid,
    input wire logic [2:0]  op_code,
    input wire logic [3:0]  op_cond,
    input wire logic [2:0]  op_breakpoint_instr_id,
    input wire logic        op_ready,
    input wire logic        bus_err,
    input wire logic        bus_ack,
    input wire logic        bus_req,
    input wire logic        bus_we,
    input wire logic        bus_breakpoint_instr_ack,
    input wire logic [31:0] bus_addr,
    input wire logic        flags_we,
    input wire logic [3:0]  flags_out,
    input wire logic        trap_take,
    input wire logic [7:0]  trap_vector,
    input wire logic        subst_valid,
    input wire logic        pc_load,
    input wire logic        rerun_req,
    input wire logic        resume
);
    // an op counts only when the unit offers ready
    wire logic take = clk_en && op_valid && op_ready;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // acknowledge end and rerun hand-over
    sequence s_bk_end;
        bus_req && bus_breakpoint_instr_ack && bus_ack;
    endsequence
    sequence s_rerun;
        rerun_req ##1 resume;
    endsequence
    property p_bcmp;
        take && op_code == 3'h1 |=> flags_we && !trap_take;
    endproperty
    property p_bchk;
        take && op_code == 3'h2 |=> flags_we && trap_take == flags_out[0];
    endproperty
    property p_ctrue;
        take && op_code == 3'h3 && op_cond == 4'h0 |=> trap_take
            && trap_vector == tbc_pkg::VEC_CTRAP;
    endproperty
    property p_cfalse;
        take && op_code == 3'h3 && op_cond == 4'h1 |=> !trap_take;
    endproperty
    property p_bkaddr;
        take && op_code == 3'h4 |=> bus_req && bus_breakpoint_instr_ack && bus_addr ==
            (tbc_pkg::ACK_SPACE | {27'h0, $past(op_breakpoint_instr_id), 2'h0});
    endproperty
    property p_hold;
        bus_req && !bus_ack && !bus_err |=> bus_req && $stable(bus_addr);
    endproperty
    property p_subst;
        s_bk_end |=> subst_valid && !trap_take;
    endproperty
    property p_bkerr;
        bus_req && bus_breakpoint_instr_ack && bus_err |=> trap_take && !subst_valid;
    endproperty
    property p_push;
        bus_err && op_ready && !op_valid && !bus_req |=> bus_req && bus_we;
    endproperty
    property p_vec;
        bus_req && !bus_we && !bus_breakpoint_instr_ack && bus_ack
            && bus_addr == 32'h8 |=> pc_load;
    endproperty
    property p_ret;
        take && op_code == 3'h5 |-> ##[1:2] bus_req && !bus_we;
    endproperty
    property p_rerun;
        rerun_req |-> s_rerun;
    endproperty
    a_bcmp: assert property (p_bcmp) else $error("compare trapped");
    a_bchk: assert property (p_bchk) else $error("check trap wrong");
    a_ctrue: assert property (p_ctrue) else $error("no trap");
    a_cfalse: assert property (p_cfalse) else $error("trap");
    a_bkaddr: assert property (p_bkaddr) else $error("ack addr");
    a_hold: assert property (p_hold) else $error("req moved");
    a_subst: assert property (p_subst) else $error("no word");
    a_bkerr: assert property (p_bkerr) else $error("no err trap");
    a_push: assert property (p_push) else $error("no push");
    a_vec: assert property (p_vec) else $error("no pc load");
    a_ret: assert property (p_ret) else $error("no pop");
    a_rerun: assert property (p_rerun) else $error("no resume");
endmodule : tbc_unit_props
bind tbc_unit tbc_unit_props u_props (.*);
`default_nettype wire
